// *** logic/fsp_params.svh ***
/*
  Constants of the four-mode serial port: register addresses, field
  positions, reset values and timing counts.
  Assumes inclusion by the package and the serial port module only.
*/
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

// ----------------------------------------------------------------
// register addresses and reset values on the special-function-register port
// ----------------------------------------------------------------
`define FSP_CTRL_ADDR 8'h98
`define FSP_BUF_ADDR 8'h99
`define FSP_CTRL_RESET 8'h00
`define FSP_BUF_RESET 8'h00

// ----------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------
`define FSP_B_MODE_HI 7
`define FSP_B_MODE_LO 6
`define FSP_B_ADDR_REC 5
`define FSP_B_RX_EN 4
`define FSP_B_TX_NINTH 3
`define FSP_B_RX_NINTH 2
`define FSP_B_TX_DONE 1
`define FSP_B_RX_DONE 0

// ----------------------------------------------------------------
// timing counts in clock cycles, sample ticks and frame bits (clk at 100 MHz)
// ----------------------------------------------------------------
`define FSP_SYNC_DIV 3'h6
`define FSP_SYNC_LAST 3'h5
`define FSP_SYNC_HALF 3'h3
`define FSP_OVS_LAST 4'hF
`define FSP_OVS_MID 4'h7
`define FSP_SYNC_BITS 4'h8
`define FSP_BITS_8 4'hA
`define FSP_BITS_9 4'hB

`endif

// *** logic/fsp_pkg.sv ***
/*
  Types of the four-mode serial port: state machines and mode codes.
  Assumes the constants header sits beside it.
*/
package fsp_pkg;
  `include "fsp_params.svh"

  // transmit and mode-0 shift engine
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_ASYNC = 3'b010,
    TX_SYNC = 3'b100
  } fsp_tx_e;

  // asynchronous receiver
  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_BUSY = 2'b10
  } fsp_rx_e;

  // serial port mode from the two mode-select bits
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_ASYNC8 = 2'b01,
    MODE_ASYNC9_FIX = 2'b10,
    MODE_ASYNC9_TMR = 2'b11
  } fsp_mode_e;
endpackage

// *** logic/fsp_serial_port.sv ***
/*
  Four-mode serial port: control register, shared data register,
  transmitter, receiver with a one-byte holding buffer, rate logic.
  Assumes a CPU register port synchronous to clk, a one-cycle timer-1
  overflow pulse, and pin inputs already synchronous to clk.
*/
// Operation
// (RL1) transmit and receive paths run independently and at the same time; mode 0 runs both through one shared engine, one at a time
// (RL2) a second byte may arrive before the first is read; it overwrites it
// (RL3) data register write loads transmit; read returns separate receive register
// (RL4) mode 0 shifts 8 bits lsb first on receive pin at clock/6
// (RL5) mode 1 frame: start 0, eight data lsb first, stop 1
// (RL6) mode 1 reception stores the stop bit in the receive ninth bit
// (RL7) modes 1 and 3 use timer-1 overflow; modes 0 and 2 fixed rates
// (RL8) modes 2 and 3 frame: start, eight data, ninth bit, stop
// (RL9) transmitted ninth bit is the last written transmit ninth-bit value
// (RL10) received ninth bit goes to receive ninth bit; stop is dropped
// (RL11) mode 2 rate is clock/32, or clock/16 when rate doubling set
// (RL12) mode 3 equals mode 2 except it uses the timer rate
// (RL13) any write of the data register starts a transmission
// (RL14) mode 0 reception starts when receive-done is 0 and enable is 1
// (RL15) async reception starts on a start bit only while enabled
// (RL16) control bit 7 shows mode bit or framing error by view select
// (RL17) missing stop bit sets framing error, held until software clears
// (RL18) control holds mode bits, ninth bits and both done flags
// (RL19) software picks the ninth bit through the transmit ninth-bit field
// (RL20) mode codes 01, 10, 11 select modes 1, 2 and 3
// (RL21) done flags set at frame end and byte load, cleared by software
`timescale 1ns/1ps
`include "fsp_params.svh"
module fsp_serial_port import fsp_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic rate_double_bit,
  input wire logic error_view_select,
  input wire logic t1_ovf,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_n,
  output logic txd
);

  // ----------------------------------------------------------------
  // register port decode and control state
  // ----------------------------------------------------------------
  logic wr_ctrl, wr_buf, rd_ctrl, rd_buf;
  logic mode_hi_q, mode_hi_d, mode_lo_q, mode_lo_d, addr_rec_q, addr_rec_d;
  logic rx_en_q, rx_en_d, tx_ninth_q, tx_ninth_d, rx_ninth_q, rx_ninth_d;
  logic tx_done_q, tx_done_d, rx_done_q, rx_done_d, fe_q, fe_d;
  logic [7:0] rbuf_q, rbuf_d, rdata_q, rdata_d, ctrl_rst;
  fsp_mode_e mode;
  // events from the shift engines
  logic tx_fin, rx_load, rx_ninth_new, fe_set;
  logic [7:0] rx_data;

  assign wr_ctrl = sfr_wr && (sfr_addr == `FSP_CTRL_ADDR);
  assign wr_buf = sfr_wr && (sfr_addr == `FSP_BUF_ADDR);
  assign rd_ctrl = sfr_rd && (sfr_addr == `FSP_CTRL_ADDR);
  assign rd_buf = sfr_rd && (sfr_addr == `FSP_BUF_ADDR);
  assign mode = fsp_mode_e'({mode_hi_q, mode_lo_q}); // RL20
  assign ctrl_rst = `FSP_CTRL_RESET;

  // control fields; hardware sets beat a software clear in the same cycle
  always_comb begin
    mode_hi_d = mode_hi_q;
    mode_lo_d = mode_lo_q;
    addr_rec_d = addr_rec_q;
    rx_en_d = rx_en_q;
    tx_ninth_d = tx_ninth_q;
    rx_ninth_d = rx_ninth_q;
    tx_done_d = tx_done_q;
    rx_done_d = rx_done_q;
    fe_d = fe_q;
    rbuf_d = rbuf_q;
    if (wr_ctrl) begin // RL18
      if (error_view_select) begin
        fe_d = sfr_wdata[`FSP_B_MODE_HI]; // RL16
      end else begin
        mode_hi_d = sfr_wdata[`FSP_B_MODE_HI];
      end
      mode_lo_d = sfr_wdata[`FSP_B_MODE_LO];
      addr_rec_d = sfr_wdata[`FSP_B_ADDR_REC];
      rx_en_d = sfr_wdata[`FSP_B_RX_EN];
      tx_ninth_d = sfr_wdata[`FSP_B_TX_NINTH];
      rx_ninth_d = sfr_wdata[`FSP_B_RX_NINTH];
      tx_done_d = sfr_wdata[`FSP_B_TX_DONE];
      rx_done_d = sfr_wdata[`FSP_B_RX_DONE];
    end
    if (tx_fin) begin
      tx_done_d = 1'b1; // RL21
    end
    if (rx_load) begin
      rbuf_d = rx_data; // RL2
      rx_done_d = 1'b1; // RL21
      if (mode != MODE_SHIFT) begin
        rx_ninth_d = rx_ninth_new; // RL6 RL10
      end
    end
    if (fe_set) begin
      fe_d = 1'b1; // RL17
    end
  end

  // read data is registered; an unmapped read returns zero
  always_comb begin
    rdata_d = 8'h00;
    if (rd_ctrl) begin
      rdata_d = {error_view_select ? fe_q : mode_hi_q, mode_lo_q, addr_rec_q, rx_en_q,
                 tx_ninth_q, rx_ninth_q, tx_done_q, rx_done_q}; // RL16
    end else if (rd_buf) begin
      rdata_d = rbuf_q; // RL3
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {mode_hi_q, mode_lo_q, addr_rec_q, rx_en_q} <= ctrl_rst[7:4];
      {tx_ninth_q, rx_ninth_q, tx_done_q, rx_done_q} <= ctrl_rst[3:0];
      fe_q <= 1'b0;
      rbuf_q <= `FSP_BUF_RESET;
      rdata_q <= 8'h00;
    end else begin
      mode_hi_q <= mode_hi_d;
      mode_lo_q <= mode_lo_d;
      addr_rec_q <= addr_rec_d;
      rx_en_q <= rx_en_d;
      tx_ninth_q <= tx_ninth_d;
      rx_ninth_q <= rx_ninth_d;
      tx_done_q <= tx_done_d;
      rx_done_q <= rx_done_d;
      fe_q <= fe_d;
      rbuf_q <= rbuf_d;
      rdata_q <= rdata_d;
    end
  end
  assign sfr_rdata = rdata_q;

  // ----------------------------------------------------------------
  // rate logic: sixteen sample ticks per asynchronous bit
  // ----------------------------------------------------------------
  logic half_q, half_d, tick_src, tick;

  // mode 2 counts clk; modes 1 and 3 count timer-1 overflows
  assign tick_src = (mode == MODE_ASYNC9_FIX) ? 1'b1 : t1_ovf; // RL7 RL11 RL12
  assign tick = tick_src && (rate_double_bit || half_q); // RL11

  always_comb begin
    half_d = half_q;
    if (tick_src) begin
      half_d = !half_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      half_q <= 1'b0;
    end else begin
      half_q <= half_d;
    end
  end

  // ----------------------------------------------------------------
  // transmitter and mode-0 shift engine (drives both pins)
  // ----------------------------------------------------------------
  fsp_tx_e tx_state_q, tx_state_d;
  logic [10:0] tx_sh_q, tx_sh_d;
  logic [3:0] tx_ph_q, tx_ph_d, tx_bit_q, tx_bit_d, tx_nbits;
  logic [2:0] sync_cnt_q, sync_cnt_d;
  logic sync_rx_q, sync_rx_d, samp_q, samp_d;
  logic txd_q, txd_d, rxd_out_q, rxd_out_d, rxd_oe_n_q, rxd_oe_n_d;
  logic sync_start, sync_done;

  assign tx_nbits = (mode == MODE_ASYNC8) ? `FSP_BITS_8 : `FSP_BITS_9;
  // a data register write takes priority over a pending mode-0 receive
  assign sync_start = (mode == MODE_SHIFT) && rx_en_q && !rx_done_q
                      && (tx_state_q == TX_IDLE) && !wr_buf; // RL14
  assign sync_done = (tx_state_q == TX_SYNC) && (sync_cnt_q == `FSP_SYNC_LAST)
                     && (tx_bit_q == `FSP_SYNC_BITS - 4'h1);

  always_comb begin
    tx_state_d = tx_state_q;
    tx_sh_d = tx_sh_q;
    tx_ph_d = tx_ph_q;
    tx_bit_d = tx_bit_q;
    sync_cnt_d = sync_cnt_q;
    sync_rx_d = sync_rx_q;
    samp_d = samp_q;
    tx_fin = 1'b0;
    case (tx_state_q)
      TX_IDLE: begin
        if (sync_start) begin
          tx_state_d = TX_SYNC; // RL14
          sync_rx_d = 1'b1;
          sync_cnt_d = 3'h0;
          tx_bit_d = 4'h0;
          tx_sh_d = 11'h7FF;
        end
      end
      TX_ASYNC: begin
        if (tick) begin
          tx_ph_d = tx_ph_q + 4'h1;
          if (tx_ph_q == `FSP_OVS_LAST) begin
            tx_sh_d = {1'b1, tx_sh_q[10:1]}; // RL5 RL8
            tx_bit_d = tx_bit_q + 4'h1;
            if (tx_bit_q == tx_nbits - 4'h1) begin
              tx_state_d = TX_IDLE;
              tx_fin = 1'b1; // RL21
            end
          end
        end
      end
      TX_SYNC: begin
        sync_cnt_d = (sync_cnt_q == `FSP_SYNC_LAST) ? 3'h0 : sync_cnt_q + 3'h1; // RL4
        if (sync_cnt_q == `FSP_SYNC_HALF) begin
          samp_d = rxd_in;
        end
        if (sync_cnt_q == `FSP_SYNC_LAST) begin
          tx_sh_d = {3'b111, sync_rx_q ? samp_q : 1'b1, tx_sh_q[7:1]}; // RL4
          tx_bit_d = tx_bit_q + 4'h1;
          if (sync_done) begin
            tx_state_d = TX_IDLE;
            tx_fin = !sync_rx_q;
          end
        end
      end
      default: begin
        tx_state_d = TX_IDLE;
      end
    endcase
    // any data register write restarts the transmitter with a new frame
    if (wr_buf) begin // RL13 RL3
      tx_bit_d = 4'h0;
      tx_ph_d = 4'h0;
      sync_cnt_d = 3'h0;
      sync_rx_d = 1'b0;
      if (mode == MODE_SHIFT) begin
        tx_state_d = TX_SYNC;
        tx_sh_d = {3'b111, sfr_wdata};
      end else begin
        tx_state_d = TX_ASYNC;
        // mode 1 puts the stop bit where the ninth bit goes
        tx_sh_d = {1'b1, (mode == MODE_ASYNC8) ? 1'b1 : tx_ninth_q, sfr_wdata, 1'b0}; // RL9 RL5
      end
    end
  end

  // pin drive: mode 0 clock low in the first half of each bit
  always_comb begin
    txd_d = 1'b1;
    rxd_out_d = 1'b1;
    rxd_oe_n_d = 1'b1;
    case (tx_state_d)
      TX_ASYNC: begin
        txd_d = tx_sh_d[0];
      end
      TX_SYNC: begin
        txd_d = (sync_cnt_d >= `FSP_SYNC_HALF); // RL4
        rxd_out_d = tx_sh_d[0];
        rxd_oe_n_d = sync_rx_d;
      end
      default: begin
        txd_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_state_q <= TX_IDLE;
      tx_sh_q <= 11'h7FF;
      tx_ph_q <= 4'h0;
      tx_bit_q <= 4'h0;
      sync_cnt_q <= 3'h0;
      sync_rx_q <= 1'b0;
      samp_q <= 1'b1;
      txd_q <= 1'b1;
      rxd_out_q <= 1'b1;
      rxd_oe_n_q <= 1'b1;
    end else begin
      tx_state_q <= tx_state_d;
      tx_sh_q <= tx_sh_d;
      tx_ph_q <= tx_ph_d;
      tx_bit_q <= tx_bit_d;
      sync_cnt_q <= sync_cnt_d;
      sync_rx_q <= sync_rx_d;
      samp_q <= samp_d;
      txd_q <= txd_d;
      rxd_out_q <= rxd_out_d;
      rxd_oe_n_q <= rxd_oe_n_d;
    end
  end
  assign txd = txd_q;
  assign rxd_out = rxd_out_q;
  assign rxd_oe_n = rxd_oe_n_q;

  // ----------------------------------------------------------------
  // asynchronous receiver, independent of the transmitter
  // ----------------------------------------------------------------
  fsp_rx_e rx_state_q, rx_state_d;
  logic [10:0] rx_sh_q, rx_sh_d, rx_ns;
  logic [3:0] rx_ph_q, rx_ph_d, rx_bit_q, rx_bit_d;
  logic rxd_prev_q, rx_done_frame;

  assign rx_ns = {rxd_in, rx_sh_q[10:1]};
  assign rx_done_frame = (rx_state_q == RX_BUSY) && tick && (rx_ph_q == `FSP_OVS_MID)
                         && (rx_bit_q == tx_nbits - 4'h1);

  // single sample at mid bit; a start bit that reads high is a glitch
  always_comb begin
    rx_state_d = rx_state_q;
    rx_sh_d = rx_sh_q;
    rx_ph_d = rx_ph_q;
    rx_bit_d = rx_bit_q;
    case (rx_state_q)
      RX_IDLE: begin
        if (rx_en_q && (mode != MODE_SHIFT) && rxd_prev_q && !rxd_in) begin // RL15
          rx_state_d = RX_BUSY;
          rx_ph_d = 4'h0;
          rx_bit_d = 4'h0;
        end
      end
      RX_BUSY: begin
        if (tick) begin // RL1
          rx_ph_d = rx_ph_q + 4'h1;
          if (rx_ph_q == `FSP_OVS_MID) begin
            rx_sh_d = rx_ns;
            rx_bit_d = rx_bit_q + 4'h1;
            if ((rx_bit_q == 4'h0 && rxd_in) || rx_done_frame) begin
              rx_state_d = RX_IDLE;
            end
          end
        end
        if (mode == MODE_SHIFT) begin
          rx_state_d = RX_IDLE;
        end
      end
      default: begin
        rx_state_d = RX_IDLE;
      end
    endcase
  end

  // completion from either the async receiver or the mode-0 engine
  always_comb begin
    rx_load = sync_done && sync_rx_q;
    rx_data = {samp_q, tx_sh_q[7:1]};
    rx_ninth_new = rx_ns[10];
    fe_set = 1'b0;
    if (rx_done_frame && (mode != MODE_SHIFT)) begin
      rx_load = 1'b1; // RL2
      fe_set = !rx_ns[10]; // RL17
      if (mode == MODE_ASYNC8) begin
        rx_data = rx_ns[9:2];
        rx_ninth_new = rx_ns[10]; // RL6
      end else begin
        rx_data = rx_ns[8:1];
        rx_ninth_new = rx_ns[9]; // RL10 RL12
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_state_q <= RX_IDLE;
      rx_sh_q <= 11'h000;
      rx_ph_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rxd_prev_q <= 1'b1;
    end else begin
      rx_state_q <= rx_state_d;
      rx_sh_q <= rx_sh_d;
      rx_ph_q <= rx_ph_d;
      rx_bit_q <= rx_bit_d;
      rxd_prev_q <= rxd_in;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  tx_done_set_a: assert property (tx_fin |=> tx_done_q) // RL21
    else $error("transmit done flag not set after frame");
  tx_start_a: assert property (wr_buf |=> tx_state_q != TX_IDLE) // RL13
    else $error("data register write did not start transmit");
  rx_buffer_a: assert property (rx_load |=> rbuf_q == $past(rx_data) && rx_done_q) // RL2
    else $error("received byte not loaded into buffer");
  fe_hold_a: assert property (fe_q && !(wr_ctrl && error_view_select) |=> fe_q) // RL17
    else $error("framing error flag dropped without software clear");
  sync_clock_a: assert property (tx_state_q == TX_SYNC |-> txd_q == (sync_cnt_q >= `FSP_SYNC_HALF)) // RL4
    else $error("mode 0 shift clock phase wrong");
  sync_rx_start_a: assert property (sync_start |=> tx_state_q == TX_SYNC && rxd_oe_n_q) // RL14
    else $error("mode 0 reception did not start");
  rx_gate_a: assert property (rx_state_q == RX_IDLE && !rx_en_q |=> rx_state_q == RX_IDLE) // RL15
    else $error("receiver started while disabled");
  start_bit_a: assert property (tx_state_q == TX_ASYNC && tx_bit_q == 4'h0 |-> !txd_q) // RL5
    else $error("start bit not low");
  stop_into_ninth_a: assert property (rx_done_frame && mode == MODE_ASYNC8
                                      |=> rx_ninth_q == $past(rx_ns[10])) // RL6
    else $error("mode 1 stop bit not stored");
  bit7_view_a: assert property (rd_ctrl && error_view_select |=> sfr_rdata[7] == $past(fe_q)) // RL16
    else $error("control bit 7 view wrong");

  async_frame_c: cover property (tx_fin && mode != MODE_SHIFT);
  rx_frame_c: cover property (rx_done_frame && mode == MODE_ASYNC9_TMR);
  sync_rx_c: cover property (rx_load && mode == MODE_SHIFT);
  fe_event_c: cover property (fe_set);

endmodule

// *** sim/fsp_remote_node.sv ***
/*
  Remote serial node: sends asynchronous frames into the receive pin
  and answers the mode-0 shift clock as a slave shift register.
  Assumes the bench resolves the receive pin from its drive and the
  port's enable, and that the pin has a pull-up.
*/
`timescale 1ns/1ps
module fsp_remote_node (
  input wire logic clk,
  input wire logic txd,
  input wire logic rxd_oe_n,
  output logic node_drv
);
  logic [7:0] sync_q;
  int sync_cnt;
  logic sync_on;

  // ----------------------------------------
  // asynchronous sender
  // ----------------------------------------
  initial begin
    node_drv = 1'b1;
    sync_on = 1'b0;
    sync_cnt = 0;
    sync_q = 8'h00;
  end

  // one bit per period, lsb first; a bad stop bit is simply a 0 here
  task automatic send_frame(input logic [10:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      node_drv = bits[i];
      repeat (per - 1) @(negedge clk);
    end
    @(negedge clk);
    node_drv = 1'b1;
  endtask

  // ----------------------------------------
  // mode-0 slave
  // ----------------------------------------
  task automatic arm_sync(input logic [7:0] b);
    sync_q = b;
    sync_cnt = 0;
    node_drv = b[0];
    sync_on = 1'b1;
  endtask

  // released pin falls back to the pull-up level
  task automatic release_line();
    sync_on = 1'b0;
    node_drv = 1'b1;
  endtask

  // next bit on each falling shift clock; the first fall opens bit 0
  always @(negedge txd) begin
    if (sync_on && rxd_oe_n) begin
      if (sync_cnt > 0 && sync_cnt < 8) node_drv = sync_q[sync_cnt];
      sync_cnt = sync_cnt + 1;
    end
  end
endmodule

// *** sim/tb.sv ***
/*
  Self-checking bench for the four-mode serial port.
  Assumes the remote node model beside it; the bench plays the CPU and timer 1.
*/
`timescale 1ns/1ps
module tb;
  import fsp_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, t1_ovf = 1'b0;
  logic rate_double_bit = 1'b1, error_view_select = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic rxd_in, rxd_out, rxd_oe_n, txd, node_drv;
  int n_errors = 0, comparisons = 0;

  // ----------------------------------------
  // clock, timer-1 overflow every 2 clocks, pin resolution
  // ----------------------------------------
  always #5 clk = ~clk;
  always @(negedge clk) t1_ovf <= ~t1_ovf;
  assign rxd_in = rxd_oe_n ? node_drv : rxd_out;

  fsp_serial_port dut_u (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .rate_double_bit(rate_double_bit),
    .error_view_select(error_view_select), .t1_ovf(t1_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n), .txd(txd));
  fsp_remote_node node (.clk(clk), .txd(txd), .rxd_oe_n(rxd_oe_n), .node_drv(node_drv));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  // read data is registered, so it is taken one cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    check(sfr_rdata, exp);
  endtask

  // samples each bit mid-period; prescaler jitter stays well inside
  task automatic cap_tx(input int per, input int n, output logic [10:0] bits);
    int w;
    bits = 11'h7FF;
    w = 0;
    // falling edges keep the look away from the edge that launches txd
    while (txd !== 1'b0 && w < 200) begin
      @(negedge clk);
      w++;
    end
    repeat (per / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      repeat (per) @(negedge clk);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rchk(8'h98, 8'h00);
    rchk(8'h99, 8'h00);
    wr(8'h55, 8'hFF);
    rchk(8'h55, 8'h00);
    rchk(8'h98, 8'h00);
  endtask

  // mode 2 at both fixed rates, ninth bit set then cleared
  task automatic t_tx_fixed();
    logic [10:0] got;
    for (int d = 1; d >= 0; d--) begin
      rate_double_bit = d[0];
      wr(8'h98, {4'b1000, d[0], 3'b000});
      wr(8'h99, 8'hA5 ^ {8{d[0]}});
      cap_tx(d ? 16 : 32, 11, got);
      check(got, {1'b1, d[0], 8'hA5 ^ {8{d[0]}}, 1'b0});
      rchk(8'h98, {4'b1000, d[0], 3'b010});
    end
    rate_double_bit = 1'b1;
  endtask

  // mode 3 sending and receiving at once, then a second byte while receive-done is still set
  task automatic t_duplex();
    logic [10:0] got;
    wr(8'h98, 8'hD0);
    fork
      begin
        wr(8'h99, 8'h3C);
        cap_tx(32, 11, got);
      end
      node.send_frame({1'b1, 1'b1, 8'hC3, 1'b0}, 11, 32);
    join
    check(got, {1'b1, 1'b0, 8'h3C, 1'b0});
    rchk(8'h99, 8'hC3);
    rchk(8'h98, 8'hD7);
    node.send_frame({1'b1, 1'b0, 8'h69, 1'b0}, 11, 32);
    rchk(8'h99, 8'h69);
    rchk(8'h98, 8'hD3);
  endtask

  // mode 1: stop bit kept, missing stop flagged and held
  task automatic t_framing();
    wr(8'h98, 8'h50);
    node.send_frame({1'b1, 8'hA1, 1'b0}, 10, 32);
    rchk(8'h98, 8'h55);
    wr(8'h98, 8'h50);
    node.send_frame({1'b0, 8'h12, 1'b0}, 10, 32);
    error_view_select = 1'b1;
    rchk(8'h98, 8'hD1);
    error_view_select = 1'b0;
    wr(8'h98, 8'h50);
    node.send_frame({1'b1, 8'h7E, 1'b0}, 10, 32);
    error_view_select = 1'b1;
    rchk(8'h98, 8'hD5);
    error_view_select = 1'b0;
    rchk(8'h98, 8'h55);
    wr(8'h98, 8'h40);
    node.send_frame({1'b1, 8'h0F, 1'b0}, 10, 32);
    rchk(8'h98, 8'h40);
    rchk(8'h99, 8'h7E);
  endtask

  // shift-register mode out, then in
  task automatic t_mode0();
    logic [7:0] got;
    int n;
    realtime t_first;
    wr(8'h98, 8'h00);
    wr(8'h99, 8'hB4);
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (txd !== 1'b0 && n < 20) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (i == 0) t_first = $realtime;
      if (i == 0) check(rxd_oe_n, 1'b0);
      if (i == 7) check(11'(int'(($realtime - t_first) / 10.0)), 11'h02A);
      n = 0;
      while (txd !== 1'b1 && n < 20) begin
        @(posedge clk);
        #1;
        n++;
      end
      got[i] = rxd_out;
    end
    check(got, 8'hB4);
    repeat (6) @(posedge clk);
    rchk(8'h98, 8'h02);
    node.arm_sync(8'h6D);
    wr(8'h98, 8'h10);
    repeat (60) @(posedge clk);
    rchk(8'h99, 8'h6D);
    rchk(8'h98, 8'h11);
    // receive-done still set, so no second mode-0 reception may begin
    repeat (60) @(posedge clk);
    rchk(8'h99, 8'h6D);
    node.release_line();
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_tx_fixed();
    t_duplex();
    t_framing();
    t_mode0();
    final_report();
  end

  // run needs about 2800 cycles; seven times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule
